// >>> hdl/tpdt_timers.v
// three 16-bit down timers with apb register access and interrupt
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "tpdt_defs.vh"

module tpdt_timers #(
    parameter SLOW_DIV = `TPDT_SLOW_DIV
) (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        sleepWake,
    output reg         irq,
    output reg  [2:0]  terminalPulse
);

    reg [2:0]  cfgRun;
    reg [2:0]  cfgSingle;
    reg [2:0]  cfgClkSrc;
    reg [7:0]  countHigh [0:2];
    reg [7:0]  countLow  [0:2];
    reg [15:0] counter   [0:2];
    reg [2:0]  loaded;
    reg [2:0]  irqStatus;
    reg [2:0]  irqMask;
    reg        wakeHold;
    reg [31:0] slowCnt;
    reg        slowTick;
    reg [31:0] next_prdata;
    reg        next_err;
    reg [2:0]  tcHit;
    reg [2:0]  doneHold;
    reg [2:0]  next_doneHold;
    reg [2:0]  next_loaded;
    reg [15:0] next_counter [0:2];
    reg [2:0]  next_irqStatus;
    integer    i;
    integer    j;
    integer    k;
    integer    m;
    integer    p;

    wire [7:0] regIdx = paddr[9:2];
    // upper address bits must be clear, else aliases would hit registers
    wire       inMap  = (paddr[11:10] == 2'b00);
    wire       setup  = psel & ~penable;
    wire       wrAcc  = psel & penable & pready & pwrite & inMap;
    wire       rdAcc  = psel & penable & pready & ~pwrite & inMap;
    wire       statRd = rdAcc & (regIdx == `TPDT_IDX_IRQ_STAT);

    function [15:0] fullCount;
        input [7:0] hi;
        input [7:0] lo;
        begin
            fullCount = {hi, lo};
        end
    endfunction

    // count enable: every cpu clock, or only on the divided slow tick
    function tickOn;
        input clkSrc;
        input slow;
        begin
            tickOn = clkSrc | slow;
        end
    endfunction

    function known;
        input [7:0] idx;
        begin
            case (idx)
                `TPDT_IDX_T0_CFG, `TPDT_IDX_T0_HIGH, `TPDT_IDX_T0_LOW,
                `TPDT_IDX_T1_CFG, `TPDT_IDX_T1_HIGH, `TPDT_IDX_T1_LOW,
                `TPDT_IDX_T2_CFG, `TPDT_IDX_T2_HIGH, `TPDT_IDX_T2_LOW,
                `TPDT_IDX_IRQ_STAT, `TPDT_IDX_IRQ_MASK,
                `TPDT_IDX_WAKE_CTRL, `TPDT_IDX_T0_COUNT,
                `TPDT_IDX_T1_COUNT, `TPDT_IDX_T2_COUNT: known = 1'b1;
                default: known = 1'b0;
            endcase
        end
    endfunction

    // slow tick approximates the 32 kHz source from the cpu clock
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slowCnt  <= 32'h0000_0000;
            slowTick <= 1'b0;
        end else if (slowCnt >= SLOW_DIV - 1) begin
            slowCnt  <= 32'h0000_0000;
            slowTick <= 1'b1;
        end else begin
            slowCnt  <= slowCnt + 32'h0000_0001;
            slowTick <= 1'b0;
        end
    end

    always @* begin
        for (i = 0; i < 3; i = i + 1) begin
            tcHit[i] = cfgRun[i] & loaded[i] & ~doneHold[i]
                & (counter[i] == 16'h0000)
                & tickOn(cfgClkSrc[i], slowTick);
        end
    end

    always @* begin
        next_prdata = 32'h0000_0000;
        next_err    = ~known(regIdx) | ~inMap;
        case (regIdx)
            `TPDT_IDX_T0_CFG:
                next_prdata = {29'h0, cfgClkSrc[0], cfgSingle[0], cfgRun[0]};
            `TPDT_IDX_T1_CFG:
                next_prdata = {29'h0, cfgClkSrc[1], cfgSingle[1], cfgRun[1]};
            `TPDT_IDX_T2_CFG:
                next_prdata = {29'h0, cfgClkSrc[2], cfgSingle[2], cfgRun[2]};
            `TPDT_IDX_T0_HIGH:   next_prdata = {24'h0, countHigh[0]};
            `TPDT_IDX_T0_LOW:    next_prdata = {24'h0, countLow[0]};
            `TPDT_IDX_T1_HIGH:   next_prdata = {24'h0, countHigh[1]};
            `TPDT_IDX_T1_LOW:    next_prdata = {24'h0, countLow[1]};
            `TPDT_IDX_T2_HIGH:   next_prdata = {24'h0, countHigh[2]};
            `TPDT_IDX_T2_LOW:    next_prdata = {24'h0, countLow[2]};
            `TPDT_IDX_IRQ_STAT:  next_prdata = {29'h0, irqStatus};
            `TPDT_IDX_IRQ_MASK:  next_prdata = {29'h0, irqMask};
            `TPDT_IDX_WAKE_CTRL: next_prdata = {31'h0, wakeHold};
            `TPDT_IDX_T0_COUNT:  next_prdata = {16'h0, counter[0]};
            `TPDT_IDX_T1_COUNT:  next_prdata = {16'h0, counter[1]};
            `TPDT_IDX_T2_COUNT:  next_prdata = {16'h0, counter[2]};
            default:             next_prdata = 32'h0000_0000;
        endcase
    end

    // no wait state: ready rises in the first access cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            pready <= 1'b0;
        else
            pready <= setup;
    end

    // read data and error are captured at setup; data holds to the next setup, the error stands one cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            // refused or write accesses return zero
            if (pwrite || next_err)
                prdata <= 32'h0000_0000;
            else
                prdata <= next_prdata;
            pslverr <= next_err;
        end else if (pready) begin
            pslverr <= 1'b0;
        end
    end

    // config bits; a finished single pass drops its own run bit unless waking
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfgRun    <= `TPDT_CFG_RESET;
            cfgSingle <= `TPDT_CFG_RESET;
            cfgClkSrc <= `TPDT_CFG_RESET;
        end else begin
            // single pass clears its own run bit unless waking
            for (j = 0; j < 3; j = j + 1) begin
                if (tcHit[j] && cfgSingle[j] && !(sleepWake && wakeHold))
                    cfgRun[j] <= 1'b0;
            end
            // a software write in the same cycle overrides the clear
            if (wrAcc) begin
                // only bits 2:0 stored; upper bits are software's duty
                case (regIdx)
                    `TPDT_IDX_T0_CFG: begin
                        cfgRun[0]    <= pwdata[`TPDT_CFG_RUN];
                        cfgSingle[0] <= pwdata[`TPDT_CFG_SINGLE];
                        cfgClkSrc[0] <= pwdata[`TPDT_CFG_CLKSRC];
                    end
                    `TPDT_IDX_T1_CFG: begin
                        cfgRun[1]    <= pwdata[`TPDT_CFG_RUN];
                        cfgSingle[1] <= pwdata[`TPDT_CFG_SINGLE];
                        cfgClkSrc[1] <= pwdata[`TPDT_CFG_CLKSRC];
                    end
                    `TPDT_IDX_T2_CFG: begin
                        cfgRun[2]    <= pwdata[`TPDT_CFG_RUN];
                        cfgSingle[2] <= pwdata[`TPDT_CFG_SINGLE];
                        cfgClkSrc[2] <= pwdata[`TPDT_CFG_CLKSRC];
                    end
                    default: ;
                endcase
            end
        end
    end

    // count bytes; the counter samples them only when it loads
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (p = 0; p < 3; p = p + 1) begin
                countHigh[p] <= `TPDT_DATA_RESET;
                countLow[p]  <= `TPDT_DATA_RESET;
            end
        end else if (wrAcc) begin
            case (regIdx)
                `TPDT_IDX_T0_HIGH: countHigh[0] <= pwdata[7:0];
                `TPDT_IDX_T0_LOW:  countLow[0]  <= pwdata[7:0];
                `TPDT_IDX_T1_HIGH: countHigh[1] <= pwdata[7:0];
                `TPDT_IDX_T1_LOW:  countLow[1]  <= pwdata[7:0];
                `TPDT_IDX_T2_HIGH: countHigh[2] <= pwdata[7:0];
                `TPDT_IDX_T2_LOW:  countLow[2]  <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // interrupt mask and the wake exception enable
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqMask  <= 3'h0;
            wakeHold <= 1'b0;
        end else if (wrAcc) begin
            if (regIdx == `TPDT_IDX_IRQ_MASK)
                irqMask <= pwdata[2:0];
            if (regIdx == `TPDT_IDX_WAKE_CTRL)
                wakeHold <= pwdata[0];
        end
    end

    // next count state; data registers read only at start or reload
    always @* begin
        for (k = 0; k < 3; k = k + 1) begin
            next_loaded[k]   = loaded[k];
            next_doneHold[k] = doneHold[k];
            next_counter[k]  = counter[k];
            if (!cfgRun[k]) begin
                next_loaded[k]   = 1'b0;
                next_doneHold[k] = 1'b0;
                next_counter[k]  = 16'h0000;
            end else if (!loaded[k]) begin
                next_loaded[k]  = 1'b1;
                next_counter[k] = fullCount(countHigh[k], countLow[k]);
            end else if (tcHit[k]) begin
                // a single pass parks at zero even if its run bit stays
                if (cfgSingle[k])
                    next_doneHold[k] = 1'b1;
                else
                    next_counter[k] = fullCount(countHigh[k],
                        countLow[k]);
            end else if (counter[k] != 16'h0000 &&
                    tickOn(cfgClkSrc[k], slowTick)) begin
                next_counter[k] = counter[k] - 16'h0001;
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loaded   <= 3'h0;
            doneHold <= 3'h0;
            for (m = 0; m < 3; m = m + 1)
                counter[m] <= 16'h0000;
        end else begin
            loaded   <= next_loaded;
            doneHold <= next_doneHold;
            for (m = 0; m < 3; m = m + 1)
                counter[m] <= next_counter[m];
        end
    end

    // sticky status; a read clears, but a same-cycle event wins
    always @* begin
        if (statRd)
            next_irqStatus = tcHit;
        else
            next_irqStatus = irqStatus | tcHit;
    end

    // irq follows the new status so a cleared bit drops it at once
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStatus     <= 3'h0;
            irq           <= 1'b0;
            terminalPulse <= 3'h0;
        end else begin
            terminalPulse <= tcHit;
            irqStatus     <= next_irqStatus;
            irq           <= |(irqMask & next_irqStatus);
        end
    end

endmodule // tpdt_timers

// >>> hdl/tpdt_defs.vh
// register map, field positions and timing constants for the timers
`ifndef TPDT_DEFS_VH
`define TPDT_DEFS_VH

`define TPDT_IDX_T0_CFG     8'hb0
`define TPDT_IDX_T0_HIGH    8'hb1
`define TPDT_IDX_T0_LOW     8'hb2
`define TPDT_IDX_T1_CFG     8'hb3
`define TPDT_IDX_T1_HIGH    8'hb4
`define TPDT_IDX_T1_LOW     8'hb5
`define TPDT_IDX_T2_CFG     8'hb6
`define TPDT_IDX_T2_HIGH    8'hb7
`define TPDT_IDX_T2_LOW     8'hb8
`define TPDT_IDX_IRQ_STAT   8'hc0
`define TPDT_IDX_IRQ_MASK   8'hc1
`define TPDT_IDX_WAKE_CTRL  8'hc2
`define TPDT_IDX_T0_COUNT   8'hc4
`define TPDT_IDX_T1_COUNT   8'hc5
`define TPDT_IDX_T2_COUNT   8'hc6

`define TPDT_CFG_RUN        0
`define TPDT_CFG_SINGLE     1
`define TPDT_CFG_CLKSRC     2
`define TPDT_CFG_RESET      3'h0
`define TPDT_DATA_RESET     8'h00

`define TPDT_CLK_HZ         100000000
`define TPDT_SLOW_HZ        32768
`define TPDT_SLOW_DIV       (`TPDT_CLK_HZ / `TPDT_SLOW_HZ)

`endif

// >>> tb/tpdt_timers_properties.sv
// port assertions for the timer register bus
`timescale 1ns/1ps
`include "tpdt_defs.vh"
module tpdt_timers_chk (
    input wire        clk,
    input wire        arst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire       setup = psel && !penable;
    wire [7:0] idx   = paddr[9:2];
    wire       inMap = paddr[11:10] == 2'h0;
    wire       rdAck = pready && !pwrite && inMap;
    wire       cfgAt = idx == `TPDT_IDX_T0_CFG || idx == `TPDT_IDX_T1_CFG
                       || idx == `TPDT_IDX_T2_CFG;
    wire       datAt = idx >= `TPDT_IDX_T0_HIGH && idx <= `TPDT_IDX_T2_LOW
                       && !cfgAt;
    chk_ready_after_setup: assert property (setup |=> pready)
        else $error("no ready after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_idle_no_ready: assert property (!psel |=> !pready)
        else $error("ready without select");
    chk_unmapped_err: assert property (setup && !inMap |=> pslverr)
        else $error("unmapped access not refused");
    chk_mapped_no_err: assert property (setup && inMap && (cfgAt || datAt)
        |=> !pslverr) else $error("mapped access refused");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_cfg_upper_zero: assert property (rdAck && cfgAt |->
        prdata[31:3] == 29'h0) else $error("config spare bits set");
    chk_data_byte_wide: assert property (rdAck && datAt |->
        prdata[31:8] == 24'h0) else $error("count byte too wide");
endmodule // tpdt_timers_chk
bind tpdt_timers tpdt_timers_chk uChk (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

// >>> tb/tb.sv
// directed bench for the three down timers
`timescale 1ns/1ps
`include "tpdt_defs.vh"
module tb;
    localparam int B = `TPDT_IDX_T0_CFG;
    logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        sleepWake = 0, pready, pslverr, irq, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0]  terminalPulse;
    int          errCount = 0, cmpCount = 0, n;
    always #5 clk = ~clk;
    // short slow tick keeps the 32 kHz case within a few cycles
    tpdt_timers #(.SLOW_DIV(4)) uut (.clk(clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleepWake(sleepWake), .irq(irq),
        .terminalPulse(terminalPulse));
    task test_done;
        $display("compares %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input logic [31:0] got, exp, input string m);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %0t %s: %h not %h", $time, m, got, exp);
        end
    endtask
    function automatic logic [11:0] adr(input int i);
        return 12'(i * 4);
    endfunction
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        check(k < 20, 1, "bus answer");
    endtask
    task wr(input int i, input logic [31:0] d);
        xfer(1, adr(i), d);
    endtask
    task rdChk(input int i, input logic [31:0] e, input string m);
        xfer(0, adr(i), 32'h0);
        check(rd, e, m);
    endtask
    // pulse is looked at as sampled on each edge; 300 means none came
    task waitPulse(input int t, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (terminalPulse[t] !== 1'b1 && c < 300);
    endtask
    task s_regs;
        for (int t = 0; t < 3; t++) begin
            for (int j = 0; j < 3; j++)
                rdChk(B + 3 * t + j, 32'h0, "reset value");
            wr(B + 3 * t + 1, 32'ha5 + t);
            rdChk(B + 3 * t + 1, 32'ha5 + t, "high byte");
            wr(B + 3 * t + 2, 32'h5a - t);
            rdChk(B + 3 * t + 2, 32'h5a - t, "low byte");
            wr(B + 3 * t, 32'h6);
            rdChk(B + 3 * t, 32'h6, "config layout");
        end
        xfer(0, 12'h400, 32'h0);
        check(err, 1, "unmapped refused");
        xfer(1, 12'h400 + adr(B + 1), 32'hff);
        check(err, 1, "aliased write refused");
        rdChk(B + 1, 32'ha5, "aliased write ignored");
    endtask
    task s_reload;
        wr(B + 7, 32'h0);
        wr(B + 8, 32'h5);
        wr(B + 6, 32'h5);
        waitPulse(2, n);
        wr(B + 8, 32'h8);
        waitPulse(2, n);
        check(n, 3, "period after data write");
        waitPulse(2, n);
        check(n, 9, "period after reload");
        wr(B + 6, 32'h0);
    endtask
    task s_period(input int t, input logic [7:0] hi, lo, input logic sel,
                  input int e);
        wr(B + 3 * t + 1, hi);
        wr(B + 3 * t + 2, lo);
        wr(B + 3 * t, {sel, 2'h1});
        waitPulse(t, n);
        waitPulse(t, n);
        check(n, e, "reload period");
        wr(B + 3 * t, 32'h0);
        rdChk(`TPDT_IDX_T0_COUNT + t, 32'h0, "stopped count");
        waitPulse(t, n);
        check(n, 300, "pulse while stopped");
    endtask
    task s_oneshot(input int t, input logic wake);
        wr(`TPDT_IDX_WAKE_CTRL, wake);
        sleepWake <= wake;
        wr(B + 3 * t + 1, 32'h0);
        wr(B + 3 * t + 2, 32'h3);
        wr(B + 3 * t, 32'h7);
        waitPulse(t, n);
        check(n < 300, 1, "single pass end");
        rdChk(B + 3 * t, {2'h3, wake}, "run bit");
        waitPulse(t, n);
        check(n, 300, "second pass");
        wr(B + 3 * t, 32'h0);
        sleepWake <= 0;
    endtask
    task s_irq;
        check(irq, 0, "masked irq");
        wr(`TPDT_IDX_IRQ_MASK, 32'h7);
        repeat (2) @(posedge clk);
        check(irq, 1, "unmasked irq");
        rdChk(`TPDT_IDX_IRQ_STAT, 32'h7, "status bits");
        repeat (2) @(posedge clk);
        check(irq, 0, "irq after status read");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1;
        s_regs;
        s_period(0, 8'h01, 8'h02, 1, 259);
        s_period(1, 8'h00, 8'h02, 0, 12);
        s_period(2, 8'h00, 8'h05, 1, 6);
        s_reload;
        for (int t = 0; t < 3; t++)
            s_oneshot(t, 0);
        s_oneshot(1, 1);
        s_irq;
        test_done;
    end
    initial begin
        #400000;
        errCount++;
        test_done;
    end
endmodule // tb
